// [logic/pld_code_reg.sv]
// Purpose: Group input register for the macro ROM, written on a strobe.
// Assumes: Strobe is a one-cycle pulse.
// Notes: Read data comes out of the register.
`timescale 1ns/10ps
module pld_code_reg
  import pldseq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [CODE_W-1:0] din,
  output logic [CODE_W-1:0] dout
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dout <= CODE_RESET;
    end else if (load) begin
      dout <= din;
    end
  end
endmodule

// [logic/pld_seq.sv]
// Purpose: List, macro ROM load and delete sequencing for the program store.
// Assumes: All inputs synchronous to CLK_SYS; low-active pulses shown as _N.
// Notes: Slot-referenced actions decode the internal nine-slot counter.
//
// How it works
// - Key release clears start, unblocking fetch control.
// - First idle fetch request presets fetch control.
// - Advance sets match; follow clears it; settle presets.
// - Idle exit permit on first slot-1 after settle.
// - Next cycle slot 4 transfers key code.
// - Transfer sets clear latch, clears fetch control.
// - Step 223 latches first input group.
// - Step 224 pulses second group clock slot 4.
// - Step 225 pulses both third clocks slot 4.
// - Step 222 address latch pulse in slot 4.
// - Address latch sets strobe; enable voltage low.
// - Capture slot 7, strobe clears slot 0.
// - Step 203 slot 1 loads new address.
// - Delete key holds erase mode until done.
// - Marker clear gate high through erase mode.
// - No marker clear before erase-or-null sets.
// - Start in erase sets flops, blocks idle exit.
// - Tick gate slot 6, then slots 2 and 7.
// - First data presets erase-insert, delayed path.
// - Marker sets match at slot 0 or 4.
// - Deleted word held in delay, path bypassed.
// - Mode clear ends operation, back to keyboard.
// - Blocked idle exit keeps micro ROM idle.
`timescale 1ns/10ps
module pld_seq
  import pldseq_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic KEY_PRESS,
  input wire logic START_KEY,
  input wire logic DELETE_KEY,
  input wire logic RESET_KEY,
  input wire logic LIST_MODE,
  input wire logic NEXT_INSTR_FETCH,
  input wire logic ADVANCE_N,
  input wire logic MARKER_ZERO,
  input wire logic NULL_WORD,
  input wire logic FIRST_DATA,
  input wire logic PRINT_DONE,
  input wire logic PROGRAM_MODE_PULSE,
  input wire logic [7:0] MICRO_STEP,
  input wire logic [CODE_W-1:0] STORE_CODE,
  output logic [3:0] SLOT,
  output logic FETCH_REQUEST,
  output logic KEYCODE_TRANSFER_N,
  output logic IDLE_EXIT_PERMIT_N,
  output logic IDLE_EXIT_ENABLE,
  output logic FIRST_GROUP_CLOCK,
  output logic SECOND_GROUP_SELECT_N,
  output logic SECOND_GROUP_CLOCK,
  output logic THIRD_GROUP_SELECT_N,
  output logic THIRD_GROUP_CLOCK_A,
  output logic THIRD_GROUP_CLOCK_B,
  output logic ROM_ADDRESS_LATCH_N,
  output logic ROM_ENABLE_VOLTAGE,
  output logic ROM_CAPTURE,
  output logic ADDRESS_LOAD_STROBE_N,
  output logic ERASE_MODE_ACTIVE_N,
  output logic MARKER_CLEAR_GATE,
  output logic MARKER_CLEAR,
  output logic RECIRCULATION_TICK_N,
  output logic DELAYED_PATH_SELECT_A,
  output logic DELAYED_PATH_SELECT_B,
  output logic OPERATION_ENABLE,
  output logic MODE_CLEAR,
  output logic [CODE_W-1:0] KEYCODE_HOLD,
  output logic [CODE_W-1:0] GROUP1_DATA
);
  import pldseq_pkg::*;

  // --------------------------------------------------------------
  // Timing slots
  // --------------------------------------------------------------
  logic [3:0] slot;
  logic key_press_q;
  logic key_release;
  logic start_flop;
  logic settle_flop;
  logic settle_clear_latch;
  logic marker_match_flop;
  logic marker_follow_flop;
  logic next_cycle_arm;
  logic erase_insert_flop;
  logic erase_or_null_flop;
  logic del_permit;
  logic mode_clear_flop;
  logic tick_run;
  logic rom_strobe_flop;
  pld_list_state_type list_state;
  pld_del_state_type del_state;
  logic at_slot0or4;
  logic group1_load;

  pld_slot_counter u_slots (
    .clk(CLK_SYS),
    .nrst(NRST),
    .slot(slot)
  );

  assign at_slot0or4 = (slot == SLOT_0) || (slot == SLOT_4);
  assign key_release = key_press_q && !KEY_PRESS;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      SLOT <= SLOT_RESET;
      key_press_q <= 1'b0;
    end else begin
      SLOT <= slot;
      key_press_q <= KEY_PRESS;
    end
  end

  // --------------------------------------------------------------
  // Start flop and idle exit enable
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      start_flop <= 1'b0;
    end else if (START_KEY && KEY_PRESS) begin
      start_flop <= 1'b1;
    end else if (key_release) begin
      start_flop <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      IDLE_EXIT_ENABLE <= 1'b0;
    end else begin
      // Blocked while a key is down or an edit mode is in force.
      IDLE_EXIT_ENABLE <= !KEY_PRESS && ERASE_MODE_ACTIVE_N;
    end
  end

  // --------------------------------------------------------------
  // Marker match and follow flops
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      marker_match_flop <= 1'b0;
    end else if (!ADVANCE_N) begin
      marker_match_flop <= 1'b1;
    end else if (MARKER_ZERO && at_slot0or4 && del_state == PLD_DEL_ROUTE) begin
      marker_match_flop <= 1'b1;
    end else if (marker_follow_flop) begin
      marker_match_flop <= 1'b0;
    end
  end

  // The follow flop clears the match flop within two cycles, so the delete path keeps its own
  // permission from the matching slot 0 or 4 until the next one.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      del_permit <= 1'b0;
    end else if (del_state != PLD_DEL_ROUTE) begin
      del_permit <= 1'b0;
    end else if (MARKER_ZERO && at_slot0or4) begin
      del_permit <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      marker_follow_flop <= 1'b0;
    end else begin
      marker_follow_flop <= marker_match_flop && !marker_follow_flop;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      KEYCODE_HOLD <= CODE_RESET;
    end else if (marker_follow_flop) begin
      KEYCODE_HOLD <= STORE_CODE;
    end
  end

  // --------------------------------------------------------------
  // Settle flop and settle-clear latch
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      settle_flop <= 1'b0;
    end else if (START_KEY && KEY_PRESS && !start_flop) begin
      settle_flop <= 1'b1;
    end else if (start_flop || (settle_clear_latch && slot == SLOT_6)) begin
      settle_flop <= 1'b0;
    end else if (marker_follow_flop) begin
      settle_flop <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      settle_clear_latch <= 1'b0;
    end else if (start_flop || !KEYCODE_TRANSFER_N) begin
      settle_clear_latch <= 1'b1;
    end else if (settle_flop == 1'b0 && !start_flop) begin
      settle_clear_latch <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // List fetch and key-code transfer
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      FETCH_REQUEST <= 1'b0;
    end else if (start_flop || KEY_PRESS || !KEYCODE_TRANSFER_N) begin
      FETCH_REQUEST <= 1'b0;
    end else if (LIST_MODE && NEXT_INSTR_FETCH && list_state == PLD_IDLE) begin
      FETCH_REQUEST <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      list_state <= PLD_IDLE;
      IDLE_EXIT_PERMIT_N <= 1'b1;
      KEYCODE_TRANSFER_N <= 1'b1;
      next_cycle_arm <= 1'b0;
    end else begin
      IDLE_EXIT_PERMIT_N <= 1'b1;
      KEYCODE_TRANSFER_N <= 1'b1;
      case (list_state)
        PLD_IDLE: begin
          if (settle_flop && IDLE_EXIT_ENABLE && slot == SLOT_1) begin
            IDLE_EXIT_PERMIT_N <= 1'b0;
            next_cycle_arm <= 1'b0;
            list_state <= PLD_KEYIN;
          end
        end
        PLD_KEYIN: begin
          if (slot == SLOT_LAST) begin
            next_cycle_arm <= 1'b1;
          end
          if (next_cycle_arm && slot == SLOT_4) begin
            KEYCODE_TRANSFER_N <= 1'b0;
            list_state <= PLD_WAIT_PRINT;
          end
        end
        PLD_WAIT_PRINT: begin
          // No return to idle until the current word is on paper.
          if (PRINT_DONE) begin
            list_state <= PLD_IDLE;
          end
        end
        default: begin
          list_state <= PLD_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Macro ROM input groups
  // --------------------------------------------------------------
  assign group1_load = (MICRO_STEP == STEP_GROUP1) && (slot == SLOT_4);

  pld_code_reg u_group1 (
    .clk(CLK_SYS),
    .nrst(NRST),
    .load(group1_load),
    .din(KEYCODE_HOLD),
    .dout(GROUP1_DATA)
  );

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      FIRST_GROUP_CLOCK <= 1'b1;
      SECOND_GROUP_SELECT_N <= 1'b1;
      SECOND_GROUP_CLOCK <= 1'b1;
      THIRD_GROUP_SELECT_N <= 1'b1;
      THIRD_GROUP_CLOCK_A <= 1'b0;
      THIRD_GROUP_CLOCK_B <= 1'b0;
      ROM_ADDRESS_LATCH_N <= 1'b1;
      ADDRESS_LOAD_STROBE_N <= 1'b1;
    end else begin
      FIRST_GROUP_CLOCK <= !group1_load;
      SECOND_GROUP_SELECT_N <= MICRO_STEP != STEP_GROUP2;
      SECOND_GROUP_CLOCK <= !(MICRO_STEP == STEP_GROUP2 && slot == SLOT_4);
      THIRD_GROUP_SELECT_N <= MICRO_STEP != STEP_GROUP3;
      THIRD_GROUP_CLOCK_A <= MICRO_STEP == STEP_GROUP3 && slot == SLOT_4;
      THIRD_GROUP_CLOCK_B <= MICRO_STEP == STEP_GROUP3 && slot == SLOT_4;
      ROM_ADDRESS_LATCH_N <= !(MICRO_STEP == STEP_ADDR_LATCH && slot == SLOT_4);
      ADDRESS_LOAD_STROBE_N <= !(MICRO_STEP == STEP_NEW_ADDR && slot == SLOT_1);
    end
  end

  // --------------------------------------------------------------
  // Macro ROM strobe and capture
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rom_strobe_flop <= 1'b0;
      ROM_ENABLE_VOLTAGE <= 1'b1;
      ROM_CAPTURE <= 1'b0;
    end else begin
      if (!ROM_ADDRESS_LATCH_N) begin
        rom_strobe_flop <= 1'b1;
      end else if (slot == SLOT_0) begin
        rom_strobe_flop <= 1'b0;
      end
      ROM_ENABLE_VOLTAGE <= !(rom_strobe_flop || !ROM_ADDRESS_LATCH_N) || slot == SLOT_0;
      ROM_CAPTURE <= rom_strobe_flop && slot == SLOT_7;
    end
  end

  // --------------------------------------------------------------
  // Delete sequence
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      del_state <= PLD_DEL_OFF;
      ERASE_MODE_ACTIVE_N <= 1'b1;
    end else if (RESET_KEY || mode_clear_flop) begin
      del_state <= PLD_DEL_OFF;
      ERASE_MODE_ACTIVE_N <= 1'b1;
    end else begin
      case (del_state)
        PLD_DEL_OFF: begin
          if (DELETE_KEY) begin
            ERASE_MODE_ACTIVE_N <= 1'b0;
            del_state <= PLD_DEL_ARMED;
          end
        end
        PLD_DEL_ARMED: begin
          if (FIRST_DATA && tick_run) begin
            del_state <= PLD_DEL_ROUTE;
          end
        end
        PLD_DEL_ROUTE: begin
          if (del_permit && at_slot0or4) begin
            del_state <= PLD_DEL_DONE;
          end
        end
        PLD_DEL_DONE: begin
          del_state <= PLD_DEL_DONE;
        end
        default: begin
          del_state <= PLD_DEL_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      erase_insert_flop <= 1'b0;
    end else if (del_state == PLD_DEL_ARMED && FIRST_DATA && tick_run) begin
      erase_insert_flop <= 1'b1;
    end else if (del_permit && at_slot0or4 && del_state == PLD_DEL_ROUTE) begin
      erase_insert_flop <= 1'b0;
    end else if (RESET_KEY) begin
      erase_insert_flop <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      mode_clear_flop <= 1'b0;
    end else if (start_flop) begin
      mode_clear_flop <= 1'b0;
    end else begin
      mode_clear_flop <= del_permit && at_slot0or4 && del_state == PLD_DEL_ROUTE;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      OPERATION_ENABLE <= 1'b0;
      MODE_CLEAR <= 1'b0;
    end else begin
      MODE_CLEAR <= mode_clear_flop;
      if (mode_clear_flop || RESET_KEY) begin
        OPERATION_ENABLE <= 1'b0;
      end else if (start_flop) begin
        OPERATION_ENABLE <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tick_run <= 1'b0;
      RECIRCULATION_TICK_N <= 1'b1;
    end else begin
      if (!OPERATION_ENABLE) begin
        tick_run <= 1'b0;
      end else if (!ERASE_MODE_ACTIVE_N && settle_clear_latch && slot == SLOT_6) begin
        tick_run <= 1'b1;
      end
      RECIRCULATION_TICK_N <= !(tick_run && (slot == SLOT_2 || slot == SLOT_7));
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      DELAYED_PATH_SELECT_A <= 1'b0;
      DELAYED_PATH_SELECT_B <= 1'b0;
    end else begin
      DELAYED_PATH_SELECT_A <= erase_insert_flop;
      DELAYED_PATH_SELECT_B <= erase_insert_flop;
    end
  end

  // --------------------------------------------------------------
  // Marker clear
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      erase_or_null_flop <= 1'b0;
    end else if (del_state == PLD_DEL_DONE || mode_clear_flop) begin
      erase_or_null_flop <= 1'b1;
    end else if (PROGRAM_MODE_PULSE) begin
      erase_or_null_flop <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      MARKER_CLEAR_GATE <= 1'b0;
      MARKER_CLEAR <= 1'b0;
    end else begin
      MARKER_CLEAR_GATE <= !ERASE_MODE_ACTIVE_N || (erase_or_null_flop && MARKER_CLEAR_GATE);
      // Clock blocked while erase mode holds, so no stray clear mid-edit.
      MARKER_CLEAR <= MARKER_CLEAR_GATE && erase_or_null_flop && NULL_WORD && ERASE_MODE_ACTIVE_N;
    end
  end
endmodule

// [logic/pld_slot_counter.sv]
// Purpose: Repeating timing slot counter, slots 0 through 8.
// Assumes: Single system clock.
// Notes: Slot value comes straight from a register.
`timescale 1ns/10ps
module pld_slot_counter
  import pldseq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  output logic [3:0] slot
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slot <= SLOT_RESET;
    end else if (slot == SLOT_LAST) begin
      slot <= SLOT_RESET;
    end else begin
      slot <= slot + 4'h1;
    end
  end
endmodule

// [logic/pldseq_pkg.sv]
// Purpose: Shared constants for the program list and delete sequencer.
// Assumes: One 100 MHz clock; slot counter of nine slots.
// Notes: Micro ROM step numbers are decimal as used by the sequencer.
package pldseq_pkg;
  localparam int SLOT_COUNT = 9;
  localparam logic [3:0] SLOT_0 = 4'h0;
  localparam logic [3:0] SLOT_1 = 4'h1;
  localparam logic [3:0] SLOT_2 = 4'h2;
  localparam logic [3:0] SLOT_4 = 4'h4;
  localparam logic [3:0] SLOT_6 = 4'h6;
  localparam logic [3:0] SLOT_7 = 4'h7;
  localparam logic [3:0] SLOT_LAST = 4'h8;
  localparam logic [3:0] SLOT_RESET = 4'h0;
  localparam logic [7:0] STEP_NEW_ADDR = 8'd203;
  localparam logic [7:0] STEP_ADDR_LATCH = 8'd222;
  localparam logic [7:0] STEP_GROUP1 = 8'd223;
  localparam logic [7:0] STEP_GROUP2 = 8'd224;
  localparam logic [7:0] STEP_GROUP3 = 8'd225;
  localparam int CODE_W = 8;
  localparam logic [7:0] CODE_RESET = 8'h00;
  typedef enum logic [1:0] {
    PLD_IDLE = 2'b00,
    PLD_KEYIN = 2'b01,
    PLD_WAIT_PRINT = 2'b11
  } pld_list_state_type;
  typedef enum logic [1:0] {
    PLD_DEL_OFF = 2'b00,
    PLD_DEL_ARMED = 2'b01,
    PLD_DEL_ROUTE = 2'b11,
    PLD_DEL_DONE = 2'b10
  } pld_del_state_type;
endpackage

// [tb/pld_far_side.sv]
// Purpose: Far side: micro ROM step source, idle fetch requests, printer.
// Assumes: Steps from the bench appear one cycle later.
// Notes: The printer is slow so that a blocked fetch can be seen.
`timescale 1ns/10ps
module pld_far_side
  import pldseq_pkg::*;
#(
  parameter int PRINT_WAIT = 30,
  parameter logic [7:0] IDLE_STEP = 8'h00
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] slot,
  input wire logic transfer_n,
  input wire logic [7:0] step_req,
  output logic [7:0] micro_step,
  output logic fetch_pulse,
  output logic print_done
);
  int pcnt;
  // ------------------------------
  // Micro ROM and printer
  // ------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      micro_step <= 8'h00;
      fetch_pulse <= 1'b0;
      print_done <= 1'b0;
      pcnt <= 0;
    end else begin
      micro_step <= step_req;
      // The idle loop asks again every slot cycle, even while blocked.
      fetch_pulse <= (slot == SLOT_0) && (micro_step == IDLE_STEP);
      pcnt <= !transfer_n ? PRINT_WAIT : (pcnt != 0 ? pcnt - 1 : 0);
      print_done <= (pcnt == 1);
    end
  end
endmodule

// [tb/pld_seq_assertions.sv]
// Purpose: Port checks for the list and delete sequencer.
// Assumes: Outputs line up with SLOT; steps are seen one cycle earlier.
// Notes: Bound to pld_seq from the bench top file.
`timescale 1ns/10ps
module pld_seq_assertions
  import pldseq_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [7:0] MICRO_STEP,
  input wire logic [3:0] SLOT,
  input wire logic FETCH_REQUEST,
  input wire logic KEYCODE_TRANSFER_N,
  input wire logic IDLE_EXIT_PERMIT_N,
  input wire logic FIRST_GROUP_CLOCK,
  input wire logic SECOND_GROUP_SELECT_N,
  input wire logic SECOND_GROUP_CLOCK,
  input wire logic THIRD_GROUP_SELECT_N,
  input wire logic THIRD_GROUP_CLOCK_A,
  input wire logic THIRD_GROUP_CLOCK_B,
  input wire logic ROM_ADDRESS_LATCH_N,
  input wire logic ROM_ENABLE_VOLTAGE,
  input wire logic ROM_CAPTURE,
  input wire logic ADDRESS_LOAD_STROBE_N,
  input wire logic RECIRCULATION_TICK_N
);
  // ------------------------------
  // Checks
  // ------------------------------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  chk_slot_wrap: assert property (SLOT == SLOT_LAST |=> SLOT == SLOT_0)
    else $error("slot did not wrap");
  chk_addr_pulse: assert property ($fell(ROM_ADDRESS_LATCH_N) |->
    SLOT == SLOT_4 && $past(MICRO_STEP) == STEP_ADDR_LATCH ##1 ROM_ADDRESS_LATCH_N) else $error("bad address latch");
  chk_group1_clock: assert property ($fell(FIRST_GROUP_CLOCK) |->
    SLOT == SLOT_4 && $past(MICRO_STEP) == STEP_GROUP1) else $error("bad first group clock");
  chk_group2_clock: assert property (!SECOND_GROUP_CLOCK |->
    SLOT == SLOT_4 && !SECOND_GROUP_SELECT_N) else $error("bad second group clock");
  chk_group3_pair: assert property (THIRD_GROUP_CLOCK_A |-> THIRD_GROUP_CLOCK_B &&
    SLOT == SLOT_4 && !THIRD_GROUP_SELECT_N ##1 !THIRD_GROUP_CLOCK_A) else $error("bad third group clocks");
  chk_strobe_enable: assert property (!ROM_ADDRESS_LATCH_N |-> ##[0:1] !ROM_ENABLE_VOLTAGE)
    else $error("enable not lowered");
  chk_capture_slot: assert property (ROM_CAPTURE |->
    SLOT == SLOT_7 && !ROM_ENABLE_VOLTAGE ##[1:3] ROM_ENABLE_VOLTAGE) else $error("bad capture");
  chk_load_strobe: assert property (!ADDRESS_LOAD_STROBE_N |->
    SLOT == SLOT_1 && $past(MICRO_STEP) == STEP_NEW_ADDR) else $error("bad load strobe");
  chk_tick_slots: assert property (!RECIRCULATION_TICK_N |-> SLOT == SLOT_2 || SLOT == SLOT_7)
    else $error("tick outside slots 2 and 7");
  chk_transfer_fetch: assert property ($fell(KEYCODE_TRANSFER_N) |->
    SLOT == SLOT_4 ##[0:2] !FETCH_REQUEST) else $error("bad key code transfer");
  chk_permit_slot: assert property (!IDLE_EXIT_PERMIT_N |-> SLOT == SLOT_1 ##1 IDLE_EXIT_PERMIT_N)
    else $error("bad idle exit permit");
  cov_transfer: cover property (!KEYCODE_TRANSFER_N);
  cov_capture: cover property (!ROM_ADDRESS_LATCH_N ##[1:8] ROM_CAPTURE);
  cov_tick: cover property (!RECIRCULATION_TICK_N);
endmodule

// [tb/pld_seq_tb.sv]
// Purpose: Self-checking bench for the list, load and delete sequencer.
// Assumes: Inputs change on the falling edge; far side is pld_far_side.
// Notes: Step rows run in one loop; walks and resets are hand-written.
`timescale 1ns/10ps
module pld_seq_tb;
  import pldseq_pkg::*;
  logic CLK_SYS = 1'b0;
  logic NRST = 1'b0;
  logic KEY_PRESS = 1'b0, START_KEY = 1'b0, DELETE_KEY = 1'b0, RESET_KEY = 1'b0, LIST_MODE = 1'b0;
  logic ADVANCE_N = 1'b1, MARKER_ZERO = 1'b0, NULL_WORD = 1'b0, FIRST_DATA = 1'b0, PROGRAM_MODE_PULSE = 1'b0;
  logic NEXT_INSTR_FETCH, PRINT_DONE, FETCH_REQUEST, KEYCODE_TRANSFER_N, IDLE_EXIT_PERMIT_N, IDLE_EXIT_ENABLE;
  logic FIRST_GROUP_CLOCK, SECOND_GROUP_SELECT_N, SECOND_GROUP_CLOCK, THIRD_GROUP_SELECT_N, THIRD_GROUP_CLOCK_A;
  logic THIRD_GROUP_CLOCK_B, ROM_ADDRESS_LATCH_N, ROM_ENABLE_VOLTAGE, ROM_CAPTURE, ADDRESS_LOAD_STROBE_N;
  logic ERASE_MODE_ACTIVE_N, MARKER_CLEAR_GATE, MARKER_CLEAR, RECIRCULATION_TICK_N, DELAYED_PATH_SELECT_A;
  logic DELAYED_PATH_SELECT_B, OPERATION_ENABLE, MODE_CLEAR;
  logic [7:0] MICRO_STEP;
  logic [7:0] step_req = 8'h00;
  logic [7:0] got;
  logic [3:0] SLOT;
  logic [CODE_W-1:0] STORE_CODE = 8'h00;
  logic [CODE_W-1:0] KEYCODE_HOLD, GROUP1_DATA;
  int n_mismatch = 0;
  int compares = 0;
  int i, n;
  // Row: step, then seen bits sel3, sel2, capture, load, g3, g2, g1, addr.
  localparam logic [15:0] ROWS [6] = '{16'h0000, 16'hcb10, 16'hde21, 16'hdf02, 16'he044, 16'he188};
  always #5 CLK_SYS = ~CLK_SYS;
  pld_seq u_pld_seq (.*);
  pld_far_side u_pld_far_side (.clk(CLK_SYS), .nrst(NRST), .slot(SLOT), .transfer_n(KEYCODE_TRANSFER_N),
    .step_req(step_req), .micro_step(MICRO_STEP), .fetch_pulse(NEXT_INSTR_FETCH), .print_done(PRINT_DONE));
  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic tick(input int k);
    repeat (k) @(negedge CLK_SYS);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic pulse_delete;
    DELETE_KEY = 1'b1;
    tick(1);
    DELETE_KEY = 1'b0;
  endtask
  initial begin
    #60000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    tick(5);
    chk(SLOT, SLOT_RESET);
    NRST = 1'b1;
    for (int r = 0; r < 6; r++) begin
      step_req = ROWS[r][15:8];
      tick(10);
      got = 8'h00;
      for (i = 0; i < 9; i++) begin
        got |= {~THIRD_GROUP_SELECT_N, ~SECOND_GROUP_SELECT_N, ROM_CAPTURE, ~ADDRESS_LOAD_STROBE_N,
          THIRD_GROUP_CLOCK_A, ~SECOND_GROUP_CLOCK, ~FIRST_GROUP_CLOCK, ~ROM_ADDRESS_LATCH_N};
        tick(1);
      end
      chk(got, ROWS[r][7:0]);
    end
    step_req = 8'h00;
    // List walk: a held key blocks fetching and idle exit.
    LIST_MODE = 1'b1;
    KEY_PRESS = 1'b1;
    START_KEY = 1'b1;
    tick(20);
    chk({FETCH_REQUEST, IDLE_EXIT_ENABLE}, 2'b00);
    KEY_PRESS = 1'b0;
    START_KEY = 1'b0;
    for (i = 0; i < 30 && FETCH_REQUEST !== 1'b1; i++) tick(1);
    chk(FETCH_REQUEST, 1'b1);
    STORE_CODE = 8'ha5;
    ADVANCE_N = 1'b0;
    tick(1);
    ADVANCE_N = 1'b1;
    // The permit pulse may come three cycles after the advance, so watch for it at once.
    for (i = 0; i < 30 && IDLE_EXIT_PERMIT_N !== 1'b0; i++) tick(1);
    chk({IDLE_EXIT_PERMIT_N, SLOT}, {1'b0, SLOT_1});
    chk(KEYCODE_HOLD, 8'ha5);
    for (i = 0; i < 20 && KEYCODE_TRANSFER_N !== 1'b0; i++) tick(1);
    chk({KEYCODE_TRANSFER_N, SLOT}, {1'b0, SLOT_4});
    tick(12);
    chk(FETCH_REQUEST, 1'b0);
    for (i = 0; i < 60 && FETCH_REQUEST !== 1'b1; i++) tick(1);
    chk(FETCH_REQUEST, 1'b1);
    // Delete walk from erase mode through mode clear.
    LIST_MODE = 1'b0;
    pulse_delete();
    tick(3);
    chk({ERASE_MODE_ACTIVE_N, MARKER_CLEAR_GATE}, 2'b01);
    PROGRAM_MODE_PULSE = 1'b1;
    NULL_WORD = 1'b1;
    tick(1);
    PROGRAM_MODE_PULSE = 1'b0;
    tick(9);
    chk(MARKER_CLEAR, 1'b0);
    NULL_WORD = 1'b0;
    KEY_PRESS = 1'b1;
    START_KEY = 1'b1;
    // Held across a whole slot cycle so that the slot-6 start of the tick gate falls inside it.
    tick(12);
    chk({IDLE_EXIT_ENABLE, OPERATION_ENABLE}, 2'b01);
    KEY_PRESS = 1'b0;
    START_KEY = 1'b0;
    tick(20);
    n = 0;
    for (i = 0; i < 18; i++) begin
      n += (RECIRCULATION_TICK_N === 1'b0);
      tick(1);
    end
    chk(16'(n), 16'h0004);
    FIRST_DATA = 1'b1;
    tick(1);
    FIRST_DATA = 1'b0;
    tick(3);
    chk({DELAYED_PATH_SELECT_A, DELAYED_PATH_SELECT_B}, 2'b11);
    MARKER_ZERO = 1'b1;
    for (i = 0; i < 30 && MODE_CLEAR !== 1'b1; i++) tick(1);
    chk(MODE_CLEAR, 1'b1);
    MARKER_ZERO = 1'b0;
    tick(3);
    chk({OPERATION_ENABLE, DELAYED_PATH_SELECT_A, ERASE_MODE_ACTIVE_N}, 3'b001);
    NULL_WORD = 1'b1;
    tick(2);
    chk(MARKER_CLEAR, 1'b1);
    NULL_WORD = 1'b0;
    // Operator reset leaves erase mode early.
    pulse_delete();
    RESET_KEY = 1'b1;
    tick(1);
    RESET_KEY = 1'b0;
    tick(3);
    chk(ERASE_MODE_ACTIVE_N, 1'b1);
    // Reset in mid-run while the macro ROM strobe is active.
    step_req = STEP_GROUP1;
    tick(13);
    chk(GROUP1_DATA, 8'ha5);
    step_req = STEP_ADDR_LATCH;
    tick(13);
    NRST = 1'b0;
    tick(1);
    chk({SLOT, ROM_ENABLE_VOLTAGE, FETCH_REQUEST, KEYCODE_HOLD}, {SLOT_RESET, 2'b10, CODE_RESET});
    NRST = 1'b1;
    step_req = 8'h00;
    tick(10);
    wrap_up();
  end
endmodule
bind pld_seq pld_seq_assertions u_pld_seq_assertions (.*);
